// [src/psq_pkg.sv]
package psq_pkg;

    // Clock figures
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYS_PERIOD_NS = 100;

    // Widths and sizes
    localparam int PC_W         = 12;
    localparam int INSTR_W      = 15;
    localparam int ROM_WORDS    = 4096;
    localparam int STACK_LEVELS = 8;
    localparam int STACK_PTR_W  = 3;
    localparam int DEPTH_W      = 4;
    localparam int NUM_IRQ      = 3;
    localparam int START_CNT_W  = 11;

    // Instruction cycle phases
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_LAST  = 2'h3;
    localparam logic [1:0] PHASE_STEP  = 2'h1;

    // Program counter loads
    localparam logic [PC_W-1:0] VEC_RESET      = 12'h000;
    localparam logic [PC_W-1:0] VEC_USB        = 12'h004;
    localparam logic [PC_W-1:0] VEC_TIMER_ZERO = 12'h008;
    localparam logic [PC_W-1:0] VEC_TIMER_ONE  = 12'h00C;
    localparam logic [PC_W-1:0] PC_STEP        = 12'h001;
    localparam logic [PC_W-1:0] PC_RESET       = VEC_RESET;

    // Interrupt source positions, lowest entry address first
    localparam int IRQ_USB        = 0;
    localparam int IRQ_TIMER_ZERO = 1;
    localparam int IRQ_TIMER_ONE  = 2;

    // Start-up delays
    localparam int WAKE_DELAY_TSYS    = 1024;
    localparam int WAKE_DELAY_CYCLES  = (WAKE_DELAY_TSYS * SYS_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int POWER_DELAY_TICKS  = 1024;
    localparam logic [START_CNT_W-1:0] WAKE_CNT_LAST  = START_CNT_W'(WAKE_DELAY_CYCLES - 1);
    localparam logic [START_CNT_W-1:0] POWER_CNT_LAST = START_CNT_W'(POWER_DELAY_TICKS - 1);
    localparam logic [START_CNT_W-1:0] START_CNT_ONE  = 11'h001;

    // Register indices; byte address is four times the index
    localparam logic [5:0] PROGRAM_COUNTER_LOW_BYTE_IDX = 6'h06;
    localparam logic [5:0] SEQ_CTRL_IDX                 = 6'h08;
    localparam logic [5:0] SEQ_STATUS_IDX               = 6'h09;
    localparam logic [5:0] TABLE_WORD_IDX               = 6'h0A;

    // Control register fields
    localparam int             CTRL_GIE_BIT    = 0;
    localparam int             CTRL_EN_LSB     = 1;
    localparam int             CTRL_W          = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET   = 4'h0;

    // Status register fields
    localparam int STAT_PEND_LSB  = 0;
    localparam int STAT_DEPTH_LSB = 4;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_VALID_BIT = 10;
    localparam int STAT_PC_LSB    = 16;

    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_START} psq_state_t;

    typedef enum logic [3:0] {
        ACT_HOLD, ACT_STEP, ACT_RET, ACT_BRANCH, ACT_TABLE,
        ACT_TBL_END, ACT_HALT, ACT_SKIP, ACT_SHORT, ACT_IRQ
    } psq_act_t;

endpackage

// [src/psq_stack_if.sv]
`timescale 1ns/10ps
interface psq_stack_if;
    logic                          push;
    logic                          pop;
    logic                          clear;
    logic [psq_pkg::PC_W-1:0]      push_addr;
    logic [psq_pkg::PC_W-1:0]      top_addr;
    logic [psq_pkg::DEPTH_W-1:0]   depth;
    logic                          full;

    modport seq (output push, pop, clear, push_addr, input top_addr, depth, full);
    modport stk (input push, pop, clear, push_addr, output top_addr, depth, full);
endinterface

// [src/psq_stack.sv]
`timescale 1ns/10ps
module psq_stack (
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst_n,
    // Sequencer side
    psq_stack_if.stk      stk
);
    import psq_pkg::*;

    localparam logic [STACK_PTR_W-1:0] PTR_ONE   = 3'h1;
    localparam logic [DEPTH_W-1:0]     DEPTH_ONE = 4'h1;
    localparam logic [DEPTH_W-1:0]     DEPTH_MAX = 4'h8;

    logic [PC_W-1:0]        mem [STACK_LEVELS];
    logic [STACK_PTR_W-1:0] ptr_reg;
    logic [DEPTH_W-1:0]     depth_reg;

    // Circular store: a push when full drops the oldest entry
    always_ff @(posedge clk) begin
        if (stk.push) begin
            mem[ptr_reg] <= stk.push_addr; // RL14
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || stk.clear) begin
            ptr_reg   <= '0;
            depth_reg <= '0;
        end else if (stk.push) begin
            ptr_reg <= ptr_reg + PTR_ONE;
            if (depth_reg != DEPTH_MAX) begin
                depth_reg <= depth_reg + DEPTH_ONE;
            end
        end else if (stk.pop && depth_reg != '0) begin
            ptr_reg   <= ptr_reg - PTR_ONE; // RL14
            depth_reg <= depth_reg - DEPTH_ONE;
        end
    end

    assign stk.top_addr = mem[ptr_reg - PTR_ONE];
    assign stk.depth    = depth_reg;
    assign stk.full     = (depth_reg == DEPTH_MAX);
endmodule

// [src/psq_sequencer.sv]
`timescale 1ns/10ps
// Summary of operation
// RL1 - Four clock phases make one instruction cycle
// RL2 - Fetch next word while executing current one
// RL3 - Control transfers add one dummy refill cycle
// RL4 - Counter advances by one after each fetch
// RL5 - True skip discards fetched word, resumes plus two
// RL6 - Low-byte write jumps within current page
// RL7 - Reset clears program counter to zero
// RL8 - Enabled USB request vectors to its entry
// RL9 - Enabled timer zero overflow vectors to entry
// RL10 - Enabled timer one overflow vectors to entry
// RL11 - Jumps load target field, returns load stack
// RL12 - Twelve-bit counter and table pointer address ROM
// RL13 - Start-up delay before running after wake or reset
// RL14 - Calls and acknowledges push, returns pop stack
// RL15 - Full stack keeps request pending until return
// RL16 - Lowest entry address wins among pending requests
module psq_sequencer (
    // Clock and reset
    input  wire logic                            CLK,
    input  wire logic                            RST_N,
    // APB slave
    input  wire logic                            PSEL,
    input  wire logic                            PENABLE,
    input  wire logic                            PWRITE,
    input  wire logic [7:0]                      PADDR,
    input  wire logic [31:0]                     PWDATA,
    output logic [31:0]                          PRDATA,
    output logic                                 PREADY,
    output logic                                 PSLVERR,
    // Program ROM
    output logic [psq_pkg::PC_W-1:0]             ROM_ADDR,
    input  wire logic [psq_pkg::INSTR_W-1:0]     ROM_DATA,
    // Execute stage
    output logic [psq_pkg::INSTR_W-1:0]          INSTR,
    output logic                                 EXEC_VALID,
    output logic [1:0]                           PHASE,
    output logic [psq_pkg::INSTR_W-1:0]          TABLE_WORD,
    input  wire logic                            EXEC_JUMP,
    input  wire logic                            EXEC_CALL,
    input  wire logic                            EXEC_RET,
    input  wire logic                            EXEC_RET_INT,
    input  wire logic                            EXEC_SKIP,
    input  wire logic                            EXEC_TABLE,
    input  wire logic                            EXEC_HALT,
    input  wire logic [psq_pkg::PC_W-1:0]        EXEC_TARGET,
    input  wire logic [psq_pkg::PC_W-1:0]        TABLE_ADDR,
    // Events
    input  wire logic                            USB_REQ,
    input  wire logic                            TIMER_ZERO_OVF,
    input  wire logic                            TIMER_ONE_OVF,
    input  wire logic                            WAKE_REQ,
    input  wire logic                            WDT_TIMEOUT,
    input  wire logic                            WDT_OSC_TICK,
    // Status
    output logic                                 INT_ACK,
    output logic                                 SEQ_RUNNING
);
    import psq_pkg::*;

    psq_stack_if stk_if ();

    psq_stack u_stack (
        .clk   (CLK),
        .rst_n (RST_N),
        .stk   (stk_if.stk)
    );

    logic [1:0]              phase_reg;
    psq_state_t              state_reg;
    logic [START_CNT_W-1:0]  start_cnt_reg;
    logic                    start_wdt_reg;
    logic [PC_W-1:0]         pc_reg;
    logic [PC_W-1:0]         pc_next;
    logic [PC_W-1:0]         rom_addr_reg;
    logic [INSTR_W-1:0]      instr_reg;
    logic [INSTR_W-1:0]      table_word_reg;
    logic                    exec_valid_reg;
    logic                    tbl_cycle_reg;
    logic [NUM_IRQ-1:0]      pend_reg;
    logic [NUM_IRQ-1:0]      irq_ready;
    logic [NUM_IRQ-1:0]      irq_clr;
    logic [NUM_IRQ-1:0]      irq_evt;
    logic [PC_W-1:0]         irq_vec;
    logic [CTRL_W-1:0]       ctrl_reg;
    logic                    pcl_pend_reg;
    logic [7:0]              pcl_val_reg;
    logic                    int_ack_reg;
    logic [31:0]             prdata_reg;
    logic                    pready_reg;
    logic                    pslverr_reg;
    logic                    boundary;
    logic                    wdt_reset;
    logic                    start_done;
    logic                    apb_commit;
    logic                    wr_pcl;
    logic                    wr_ctrl;
    logic [5:0]              reg_idx;
    logic                    reg_hit;
    logic [31:0]             rd_value;
    psq_act_t                act;

    // Phase counter, one instruction cycle per wrap
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            phase_reg <= PHASE_FIRST;
        end else begin
            phase_reg <= phase_reg + PHASE_STEP; // RL1
        end
    end

    assign boundary  = (phase_reg == PHASE_LAST); // RL1
    assign wdt_reset = WDT_TIMEOUT && (state_reg == ST_RUN);

    // Interrupt selection, lowest entry first
    assign irq_evt = {TIMER_ONE_OVF, TIMER_ZERO_OVF, USB_REQ};
    assign irq_ready = pend_reg & ctrl_reg[CTRL_EN_LSB +: NUM_IRQ]
                     & {NUM_IRQ{ctrl_reg[CTRL_GIE_BIT] && !stk_if.full}}; // RL15

    always_comb begin
        irq_vec = VEC_USB;
        irq_clr = '0;
        if (irq_ready[IRQ_USB]) begin
            irq_vec          = VEC_USB; // RL8 RL16
            irq_clr[IRQ_USB] = 1'b1;
        end else if (irq_ready[IRQ_TIMER_ZERO]) begin
            irq_vec                 = VEC_TIMER_ZERO; // RL9 RL16
            irq_clr[IRQ_TIMER_ZERO] = 1'b1;
        end else if (irq_ready[IRQ_TIMER_ONE]) begin
            irq_vec                = VEC_TIMER_ONE; // RL10
            irq_clr[IRQ_TIMER_ONE] = 1'b1;
        end
    end

    // Action taken at the end of the instruction cycle
    always_comb begin
        act = ACT_HOLD;
        if (boundary && state_reg == ST_RUN && !WDT_TIMEOUT) begin
            if (tbl_cycle_reg) begin
                act = ACT_TBL_END;
            end else if (exec_valid_reg && (EXEC_RET || EXEC_RET_INT)) begin
                act = ACT_RET;
            end else if (exec_valid_reg && (EXEC_JUMP || EXEC_CALL)) begin
                act = ACT_BRANCH;
            end else if (exec_valid_reg && EXEC_TABLE) begin
                act = ACT_TABLE;
            end else if (exec_valid_reg && EXEC_HALT) begin
                act = ACT_HALT;
            end else if (exec_valid_reg && EXEC_SKIP) begin
                act = ACT_SKIP;
            end else if (pcl_pend_reg) begin
                act = ACT_SHORT;
            end else if (irq_ready != '0) begin
                act = ACT_IRQ;
            end else begin
                act = ACT_STEP;
            end
        end
    end

    always_comb begin
        pc_next = pc_reg;
        unique case (act)
            ACT_STEP:    pc_next = pc_reg + PC_STEP; // RL4
            ACT_TABLE:   pc_next = pc_reg + PC_STEP; // RL4
            ACT_SKIP:    pc_next = pc_reg + PC_STEP; // RL5
            ACT_RET:     pc_next = stk_if.top_addr; // RL11
            ACT_BRANCH:  pc_next = EXEC_TARGET; // RL11
            ACT_SHORT:   pc_next = {pc_reg[PC_W-1:8], pcl_val_reg}; // RL6
            ACT_IRQ:     pc_next = irq_vec;
            ACT_TBL_END: pc_next = pc_reg;
            ACT_HALT:    pc_next = pc_reg;
            ACT_HOLD:    pc_next = pc_reg;
        endcase
    end

    // Return stack traffic
    assign stk_if.push      = (act == ACT_IRQ) || (act == ACT_BRANCH && EXEC_CALL); // RL14
    assign stk_if.push_addr = pc_reg;
    assign stk_if.pop       = (act == ACT_RET); // RL14
    assign stk_if.clear     = wdt_reset;

    // Program counter
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pc_reg <= PC_RESET; // RL7
        end else if (wdt_reset) begin
            pc_reg <= VEC_RESET; // RL7
        end else begin
            pc_reg <= pc_next;
        end
    end

    // Fetch address, from counter or from table pointer
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rom_addr_reg <= PC_RESET;
        end else if (wdt_reset) begin
            rom_addr_reg <= VEC_RESET;
        end else if (act == ACT_TABLE) begin
            rom_addr_reg <= TABLE_ADDR; // RL12
        end else if (boundary) begin
            rom_addr_reg <= pc_next; // RL12
        end
    end

    // Pipeline: word fetched this cycle executes in the next
    always_ff @(posedge CLK) begin
        if (!RST_N || wdt_reset) begin
            instr_reg      <= '0;
            exec_valid_reg <= 1'b0;
            tbl_cycle_reg  <= 1'b0;
        end else if (boundary) begin
            unique case (act)
                ACT_STEP: begin
                    instr_reg      <= ROM_DATA; // RL2
                    exec_valid_reg <= 1'b1;
                end
                ACT_TABLE: begin
                    instr_reg      <= ROM_DATA;
                    exec_valid_reg <= 1'b0;
                    tbl_cycle_reg  <= 1'b1;
                end
                ACT_TBL_END: begin
                    exec_valid_reg <= 1'b1;
                    tbl_cycle_reg  <= 1'b0;
                end
                default: begin
                    exec_valid_reg <= 1'b0; // RL3 RL5
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            table_word_reg <= '0;
        end else if (act == ACT_TBL_END) begin
            table_word_reg <= ROM_DATA; // RL12
        end
    end

    // Run, halt and start-up
    assign start_done = start_wdt_reg ? (WDT_OSC_TICK && start_cnt_reg == POWER_CNT_LAST)
                                      : (start_cnt_reg == WAKE_CNT_LAST);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg     <= ST_START; // RL13
            start_wdt_reg <= 1'b1;
            start_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (WDT_TIMEOUT) begin
                        state_reg     <= ST_START; // RL13
                        start_wdt_reg <= 1'b1;
                        start_cnt_reg <= '0;
                    end else if (act == ACT_HALT) begin
                        state_reg <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    if (WAKE_REQ || WDT_TIMEOUT) begin
                        state_reg     <= ST_START; // RL13
                        start_wdt_reg <= 1'b0;
                        start_cnt_reg <= '0;
                    end
                end
                ST_START: begin
                    if (start_done) begin
                        state_reg <= ST_RUN;
                    end else if (!start_wdt_reg || WDT_OSC_TICK) begin
                        start_cnt_reg <= start_cnt_reg + START_CNT_ONE; // RL13
                    end
                end
            endcase
        end
    end

    // Request flags; a new request wins over its acknowledge
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++) begin : g_pend
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    pend_reg[gi] <= 1'b0;
                end else if (irq_evt[gi]) begin
                    pend_reg[gi] <= 1'b1; // RL15
                end else if (act == ACT_IRQ && irq_clr[gi]) begin
                    pend_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            int_ack_reg <= 1'b0;
        end else begin
            int_ack_reg <= (act == ACT_IRQ);
        end
    end

    // Register bus
    assign reg_idx    = PADDR[7:2];
    assign apb_commit = PSEL && PENABLE && pready_reg;
    assign wr_pcl     = apb_commit && PWRITE && reg_idx == PROGRAM_COUNTER_LOW_BYTE_IDX;
    assign wr_ctrl    = apb_commit && PWRITE && reg_idx == SEQ_CTRL_IDX;
    assign reg_hit    = (reg_idx == PROGRAM_COUNTER_LOW_BYTE_IDX) || (reg_idx == SEQ_CTRL_IDX)
                     || (reg_idx == SEQ_STATUS_IDX) || (reg_idx == TABLE_WORD_IDX);

    always_comb begin
        rd_value = '0;
        unique case (reg_idx)
            PROGRAM_COUNTER_LOW_BYTE_IDX: rd_value = 32'(pc_reg[7:0]); // RL6
            SEQ_CTRL_IDX:                 rd_value = 32'(ctrl_reg);
            SEQ_STATUS_IDX: begin
                rd_value = (32'(pend_reg) << STAT_PEND_LSB)
                         | (32'(stk_if.depth) << STAT_DEPTH_LSB)
                         | (32'(state_reg) << STAT_STATE_LSB)
                         | (32'(exec_valid_reg) << STAT_VALID_BIT)
                         | (32'(pc_reg) << STAT_PC_LSB);
            end
            TABLE_WORD_IDX:               rd_value = 32'(table_word_reg);
            default:                      rd_value = '0;
        endcase
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else if (PSEL && PENABLE && !pready_reg) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !reg_hit;
            prdata_reg  <= PWRITE ? '0 : rd_value;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // Short jump request, applied at the next cycle end with no return, jump, call, skip, table or halt
    always_ff @(posedge CLK) begin
        if (!RST_N || wdt_reset) begin
            pcl_pend_reg <= 1'b0;
            pcl_val_reg  <= '0;
        end else if (wr_pcl) begin
            pcl_pend_reg <= 1'b1; // RL6
            pcl_val_reg  <= PWDATA[7:0];
        end else if (act == ACT_SHORT) begin
            pcl_pend_reg <= 1'b0;
        end
    end

    // Enables; acknowledge masks, interrupt return unmasks
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= PWDATA[CTRL_W-1:0];
        end else if (act == ACT_IRQ) begin
            ctrl_reg[CTRL_GIE_BIT] <= 1'b0;
        end else if (act == ACT_RET && EXEC_RET_INT) begin
            ctrl_reg[CTRL_GIE_BIT] <= 1'b1;
        end
    end

    assign PRDATA      = prdata_reg;
    assign PREADY      = pready_reg;
    assign PSLVERR     = pslverr_reg;
    assign ROM_ADDR    = rom_addr_reg;
    assign INSTR       = instr_reg;
    assign EXEC_VALID  = exec_valid_reg;
    assign PHASE       = phase_reg;
    assign TABLE_WORD  = table_word_reg;
    assign INT_ACK     = int_ack_reg;
    assign SEQ_RUNNING = (state_reg == ST_RUN);
endmodule

// [dv/psq_sequencer_assertions.sv]
`timescale 1ns/10ps
module psq_sequencer_assertions (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic [11:0] ROM_ADDR,
    input wire logic [14:0] ROM_DATA,
    input wire logic [14:0] INSTR,
    input wire logic        EXEC_VALID,
    input wire logic [1:0]  PHASE,
    input wire logic        EXEC_JUMP,
    input wire logic        EXEC_CALL,
    input wire logic        EXEC_RET,
    input wire logic        EXEC_RET_INT,
    input wire logic        EXEC_SKIP,
    input wire logic        EXEC_TABLE,
    input wire logic        EXEC_HALT,
    input wire logic [11:0] EXEC_TARGET,
    input wire logic        WDT_TIMEOUT,
    input wire logic        INT_ACK,
    input wire logic        SEQ_RUNNING
);
    logic end_c;
    logic br_c;
    logic plain_c;
    // Executor inputs count only at a valid cycle end
    assign end_c   = SEQ_RUNNING && PHASE == 2'h3 && EXEC_VALID;
    assign br_c    = EXEC_RET || EXEC_RET_INT || EXEC_JUMP || EXEC_CALL;
    assign plain_c = !(br_c || EXEC_SKIP || EXEC_TABLE || EXEC_HALT);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_phase; SEQ_RUNNING ##1 SEQ_RUNNING |-> PHASE == $past(PHASE) + 2'h1; endproperty
    a_phase: assert property (p_phase) else $error("phase did not step");
    property p_step; end_c && plain_c |=> !EXEC_VALID ||
        (ROM_ADDR == $past(ROM_ADDR) + 12'h001 && INSTR == $past(ROM_DATA)); endproperty
    a_step: assert property (p_step) else $error("plain step wrong");
    property p_hold; SEQ_RUNNING && PHASE != 2'h3 && !WDT_TIMEOUT
        |=> $stable(ROM_ADDR) && $stable(INSTR); endproperty
    a_hold: assert property (p_hold) else $error("fetch changed mid cycle");
    property p_jump; end_c && !EXEC_RET && !EXEC_RET_INT && (EXEC_JUMP || EXEC_CALL)
        |=> !EXEC_VALID && ROM_ADDR == $past(EXEC_TARGET); endproperty
    a_jump: assert property (p_jump) else $error("jump load wrong");
    property p_skip; end_c && EXEC_SKIP && !br_c && !EXEC_TABLE && !EXEC_HALT
        |=> !EXEC_VALID && ROM_ADDR == $past(ROM_ADDR) + 12'h001; endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");
    property p_ret; end_c && (EXEC_RET || EXEC_RET_INT) |=> (!EXEC_VALID)[*4]; endproperty
    a_ret: assert property (p_ret) else $error("no refill cycle");
    property p_reset; $rose(RST_N) |-> ROM_ADDR == 12'h000 && PHASE == 2'h0 && !EXEC_VALID;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_vec; INT_ACK |-> !EXEC_VALID && PHASE == 2'h0 &&
        ROM_ADDR inside {12'h004, 12'h008, 12'h00C} ##1 !INT_ACK; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    c_skip: cover property (end_c && EXEC_SKIP);
    c_vec: cover property (INT_ACK && ROM_ADDR == 12'h00C);
    c_run: cover property ($rose(SEQ_RUNNING));
endmodule
bind psq_sequencer psq_sequencer_assertions u_chk (
    .CLK, .RST_N, .ROM_ADDR, .ROM_DATA, .INSTR, .EXEC_VALID, .PHASE, .EXEC_JUMP,
    .EXEC_CALL, .EXEC_RET, .EXEC_RET_INT, .EXEC_SKIP, .EXEC_TABLE, .EXEC_HALT,
    .EXEC_TARGET, .WDT_TIMEOUT, .INT_ACK, .SEQ_RUNNING
);

// [dv/psq_rom_model.sv]
`timescale 1ns/10ps
module psq_rom_model (
    input wire logic        clk,
    input wire logic        slow,
    input wire logic [11:0] addr,
    output logic [14:0]     data
);
    logic [14:0] late_reg;
    logic [14:0] word_now;
    // Each of the 4096 words holds a distinct 15-bit value
    assign word_now = {3'h5, addr ^ 12'hA5A};
    always_ff @(posedge clk) begin
        late_reg <= word_now;
    end
    // Slow mode answers a clock late, still inside the fetch window
    assign data = slow ? late_reg : word_now;
endmodule

// [dv/psq_sequencer_tb.sv]
`timescale 1ns/10ps
module psq_sequencer_tb;
    logic        CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic        PREADY, PSLVERR, EXEC_VALID, INT_ACK, SEQ_RUNNING;
    logic [11:0] ROM_ADDR;
    logic [14:0] ROM_DATA, INSTR, TABLE_WORD;
    logic [1:0]  PHASE;
    logic [6:0]  ops = 7'h00;
    logic [11:0] EXEC_TARGET = 12'h000;
    logic [2:0]  evt = 3'h0;
    logic        WDT_OSC_TICK = 1'b0;
    logic        slow = 1'b0;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    always #50 CLK = ~CLK;
    psq_rom_model rom (.clk(CLK), .slow(slow), .addr(ROM_ADDR), .data(ROM_DATA));
    psq_sequencer dut (
        .CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .ROM_ADDR, .ROM_DATA, .INSTR, .EXEC_VALID, .PHASE, .TABLE_WORD,
        .EXEC_JUMP(ops[6]), .EXEC_CALL(ops[5]), .EXEC_RET(ops[4]), .EXEC_RET_INT(ops[3]),
        .EXEC_SKIP(ops[2]), .EXEC_TABLE(ops[1]), .EXEC_HALT(ops[0]), .EXEC_TARGET,
        .TABLE_ADDR(EXEC_TARGET), .USB_REQ(evt[0]), .TIMER_ZERO_OVF(evt[1]),
        .TIMER_ONE_OVF(evt[2]), .WAKE_REQ(1'b0), .WDT_TIMEOUT(1'b0), .WDT_OSC_TICK,
        .INT_ACK, .SEQ_RUNNING
    );
    function automatic logic [14:0] word(input logic [11:0] a);
        return {3'h5, a ^ 12'hA5A};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK) #1;
    endtask
    // Executor op lands on the phase-3 edge of a valid cycle
    task automatic exec(input logic [6:0] op, input logic [11:0] t, output logic [11:0] pc);
        do @(posedge CLK) #1; while (!(PHASE === 2'h2 && EXEC_VALID === 1'b1));
        pc = ROM_ADDR;
        @(posedge CLK);
        ops <= op;
        EXEC_TARGET <= t;
        @(posedge CLK);
        ops <= 7'h00;
        #1;
    endtask
    task automatic land(input logic [11:0] t);
        chk("dummy valid", 0, EXEC_VALID);
        chk("load address", t, ROM_ADDR);
        repeat (4) @(posedge CLK);
        #1 chk("executed word", word(t), INSTR);
        chk("next address", t + 12'h001, ROM_ADDR);
    endtask
    task automatic t_start;
        int n = 0;
        chk("reset address", 12'h000, ROM_ADDR);
        while (SEQ_RUNNING !== 1'b1 && n < 1100) begin
            @(posedge CLK) WDT_OSC_TICK <= 1'b1;
            @(posedge CLK) WDT_OSC_TICK <= 1'b0;
            #1 n++;
        end
        chk("start ticks", 1024, n);
    endtask
    task automatic t_step;
        logic [11:0] p;
        slow <= 1'b1;
        repeat (3) begin
            exec(7'h00, 12'h000, p);
            chk("step address", p + 12'h001, ROM_ADDR);
            chk("step word", word(p), INSTR);
        end
        slow <= 1'b0;
    endtask
    task automatic t_jump;
        logic [11:0] p;
        exec(7'h40, 12'h3F0, p);
        land(12'h3F0);
    endtask
    task automatic t_call;
        logic [11:0] p;
        logic [11:0] q;
        exec(7'h20, 12'h250, p);
        land(12'h250);
        exec(7'h10, 12'h000, q);
        land(p);
    endtask
    task automatic t_skip;
        logic [11:0] p;
        exec(7'h04, 12'h000, p);
        land(p + 12'h001);
        exec(7'h02, 12'h7C1, p);
        chk("table address", 12'h7C1, ROM_ADDR);
        repeat (4) @(posedge CLK);
        #1 chk("table word", word(12'h7C1), TABLE_WORD);
    endtask
    task automatic t_low;
        logic [31:0] q;
        logic        e;
        logic [3:0]  hi;
        hi = ROM_ADDR[11:8];
        apb(1'b1, 8'h18, 32'h00000034, q, e);
        while (EXEC_VALID !== 1'b0) @(posedge CLK) #1;
        chk("short jump", {hi, 8'h34}, ROM_ADDR);
    endtask
    task automatic t_irq;
        logic [31:0] q;
        logic        e;
        logic [11:0] p;
        logic [11:0] v [3] = '{12'h004, 12'h008, 12'h00C};
        apb(1'b0, 8'hFC, 32'h0, q, e);
        chk("unmapped error", 1, e);
        apb(1'b1, 8'h20, 32'h0000000F, q, e);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk("control", 32'h0000000F, q);
        @(posedge CLK) evt <= 3'h7;
        @(posedge CLK) evt <= 3'h0;
        #1;
        foreach (v[i]) begin
            while (INT_ACK !== 1'b1) @(posedge CLK) #1;
            chk("vector", v[i], ROM_ADDR);
            exec(7'h08, 12'h000, p);
        end
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop;
        end
    end
    initial begin
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK) #1;
        t_start;
        t_step;
        t_jump;
        t_call;
        t_skip;
        t_low;
        t_irq;
        report_and_stop;
    end
endmodule
